// >>> inc/sbs_defines.svh
`ifndef SBS_DEFINES_SVH
`define SBS_DEFINES_SVH

// ----------------------------------------
// array geometry
// ----------------------------------------
`define SBS_ADDR_W            4
`define SBS_DATA_W            18
`define SBS_DEPTH             16

// ----------------------------------------
// sleep sequencing, in clock cycles
// ----------------------------------------
`define SBS_SLEEP_ENTRY_CYC   2'h2
`define SBS_SLEEP_WAKE_CYC    2'h2

// ----------------------------------------
// register map (byte addresses) and fields
// ----------------------------------------
`define SBS_REG_CTRL          4'h0
`define SBS_REG_STATUS        4'h4
`define SBS_CTRL_SLEEP_BIT    0
`define SBS_CTRL_RESET        1'h0
`define SBS_STEP_RESET        2'h0
`define SBS_STRAP_PIPE_RESET  2'h3
`define SBS_SYNC_LOW_RESET    2'h0

`endif

// >>> inc/sbs_pkg.sv
package sbs_pkg;

  // ----------------------------------------
  // sleep sequencer, gray along awake-enter-asleep-wake
  // ----------------------------------------
  typedef enum logic [1:0] {
    SBS_AWAKE  = 2'h0,
    SBS_ENTER  = 2'h1,
    SBS_ASLEEP = 2'h3,
    SBS_WAKE   = 2'h2
  } sbs_sleep_e;

  // ----------------------------------------
  // read/write control state: kind of the current cycle
  // ----------------------------------------
  typedef enum logic [1:0] {
    SBS_OP_DESEL = 2'h0,
    SBS_OP_READ  = 2'h1,
    SBS_OP_WRITE = 2'h3,
    SBS_OP_ABORT = 2'h2
  } sbs_op_e;

endpackage

// >>> hdl/sbs_mem.sv
`include "sbs_defines.svh"

module sbs_mem import sbs_pkg::*; (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic                    wr_en,
  input  wire logic [`SBS_ADDR_W-1:0]  wr_addr,
  input  wire logic [`SBS_DATA_W-1:0]  wr_data,
  input  wire logic                    rd_en,
  input  wire logic [`SBS_ADDR_W-1:0]  rd_addr,
  output logic      [`SBS_DATA_W-1:0]  rd_data
);

  logic [`SBS_DATA_W-1:0] mem_q [`SBS_DEPTH];
  logic [`SBS_DATA_W-1:0] rd_data_q;

  // array has no reset: contents survive everything but power
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data_q <= '0;
    end else if (rd_en) begin
      rd_data_q <= mem_q[rd_addr];
    end
  end

  assign rd_data = rd_data_q;

endmodule

// >>> hdl/sbs_ctrl.sv
`include "sbs_defines.svh"


module sbs_ctrl import sbs_pkg::*; (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic                    clk_en,
  input  wire logic [`SBS_ADDR_W-1:0]  addr_in,
  input  wire logic                    advance_load,
  input  wire logic                    chip_sel,
  input  wire logic                    write_req,
  input  wire logic                    byte_wr,
  input  wire logic [`SBS_DATA_W-1:0]  wdata,
  input  wire logic                    burst_order_select,
  input  wire logic                    flow_through_select,
  input  wire logic                    sleep_request,
  output logic      [`SBS_DATA_W-1:0]  rdata,
  output logic                         rdata_oe,
  output logic                         asleep,
  output logic      [`SBS_ADDR_W-1:0]  burst_addr,
  input  wire logic [3:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest
);

  function automatic logic [1:0] sbs_burst_lo(input logic [1:0] start,
                                              input logic [1:0] step,
                                              input logic       ilv);
    sbs_burst_lo = ilv ? (start ^ step) : (start + step);
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] ft_sync_q;
  logic [1:0] bo_sync_q;
  logic [1:0] slp_sync_q;
  logic       pipeline_mode;
  logic       interleave_mode;
  logic       ctrl_sleep_q;
  logic       sleep_req_eff;

  // straps assumed static, so a plain two-stage sync suffices
  // sleep path runs without clk_en so a stalled clock cannot block sleep
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ft_sync_q  <= `SBS_STRAP_PIPE_RESET;
      bo_sync_q  <= `SBS_SYNC_LOW_RESET;
      slp_sync_q <= `SBS_SYNC_LOW_RESET;
    end else begin
      ft_sync_q  <= {ft_sync_q[0], flow_through_select};
      bo_sync_q  <= {bo_sync_q[0], burst_order_select};
      slp_sync_q <= {slp_sync_q[0], sleep_request};
    end
  end

  assign pipeline_mode   = ft_sync_q[1];
  assign interleave_mode = bo_sync_q[1];
  assign sleep_req_eff   = slp_sync_q[1] | ctrl_sleep_q;

  // ----------------------------------------
  // sleep sequencer
  // ----------------------------------------
  sbs_sleep_e sleep_q;
  sbs_sleep_e sleep_d;
  logic [1:0] slp_cnt_q;
  logic [1:0] slp_cnt_d;
  logic       asleep_q;
  logic       asleep_d;

  always_comb begin
    sleep_d   = sleep_q;
    slp_cnt_d = slp_cnt_q;
    case (sleep_q)
      SBS_AWAKE: begin
        if (sleep_req_eff) begin
          sleep_d   = SBS_ENTER;
          slp_cnt_d = '0;
        end
      end
      SBS_ENTER: begin
        // operations keep running here; host has drained them
        if (!sleep_req_eff) begin
          sleep_d = SBS_AWAKE;
        end else if (slp_cnt_q == (`SBS_SLEEP_ENTRY_CYC - 2'h1)) begin
          sleep_d = SBS_ASLEEP;
        end else begin
          slp_cnt_d = slp_cnt_q + 2'h1;
        end
      end
      SBS_ASLEEP: begin
        if (!sleep_req_eff) begin
          sleep_d   = SBS_WAKE;
          slp_cnt_d = '0;
        end
      end
      SBS_WAKE: begin
        if (sleep_req_eff) begin
          sleep_d   = SBS_ENTER;
          slp_cnt_d = '0;
        end else if (slp_cnt_q == (`SBS_SLEEP_WAKE_CYC - 2'h1)) begin
          sleep_d = SBS_AWAKE;
        end else begin
          slp_cnt_d = slp_cnt_q + 2'h1;
        end
      end
      default: begin
        sleep_d = SBS_AWAKE;
      end
    endcase
    asleep_d = (sleep_d == SBS_ASLEEP);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sleep_q   <= SBS_AWAKE;
      slp_cnt_q <= '0;
      asleep_q  <= 1'b0;
    end else begin
      sleep_q   <= sleep_d;
      slp_cnt_q <= slp_cnt_d;
      asleep_q  <= asleep_d;
    end
  end

  // ----------------------------------------
  // burst address, control and data pipelines
  // ----------------------------------------
  logic                   run;
  logic                   quiet_d;
  logic [`SBS_ADDR_W-1:0] base_q, base_d;
  logic [1:0]             step_q, step_d;
  sbs_op_e                s1_op_q, s1_op_d, s2_op_q, s2_op_d;
  logic [`SBS_ADDR_W-1:0] s1_addr_q, s1_addr_d, s2_addr_q, s2_addr_d;
  logic [`SBS_ADDR_W-1:0] cur_addr;
  logic [`SBS_ADDR_W-1:0] burst_addr_q, burst_addr_d;
  logic                   rd1_q, rd1_d, rd2_q, rd2_d;
  logic [`SBS_DATA_W-1:0] pipe_q, pipe_d, rdata_q, rdata_d;
  logic                   rdata_oe_q, rdata_oe_d;
  logic                   mem_we, mem_re;
  logic [`SBS_ADDR_W-1:0] mem_waddr;
  logic [`SBS_DATA_W-1:0] mem_rdata;

  // wake recovery freezes the pipelines like sleep; host sends no writes then
  assign run     = clk_en && (sleep_q == SBS_AWAKE || sleep_q == SBS_ENTER);
  assign quiet_d = (sleep_d == SBS_ASLEEP) || (sleep_d == SBS_WAKE);

  always_comb begin
    base_d       = base_q;
    step_d       = step_q;
    s1_op_d      = s1_op_q;
    s1_addr_d    = s1_addr_q;
    s2_op_d      = s2_op_q;
    s2_addr_d    = s2_addr_q;
    burst_addr_d = burst_addr_q;
    rd1_d        = rd1_q;
    rd2_d        = rd2_q;
    pipe_d       = pipe_q;
    rdata_d      = rdata_q;
    rdata_oe_d   = rdata_oe_q;
    mem_we       = 1'b0;
    mem_re       = 1'b0;
    mem_waddr    = pipeline_mode ? s2_addr_q : s1_addr_q;
    // frozen when held, asleep or waking: nothing in this branch moves
    if (run) begin
      if (!advance_load) begin
        if (chip_sel) begin
          base_d = addr_in;
          step_d = `SBS_STEP_RESET;
          if (write_req) begin
            s1_op_d = byte_wr ? SBS_OP_WRITE : SBS_OP_ABORT;
          end else begin
            s1_op_d = SBS_OP_READ;
          end
        end else begin
          s1_op_d = SBS_OP_DESEL;
        end
      end else begin
        step_d = step_q + 2'h1;
        case (s1_op_q)
          SBS_OP_DESEL: s1_op_d = SBS_OP_DESEL;
          SBS_OP_READ:  s1_op_d = SBS_OP_READ;
          default:      s1_op_d = byte_wr ? SBS_OP_WRITE : SBS_OP_ABORT;
        endcase
      end
      s1_addr_d    = cur_addr;
      burst_addr_d = cur_addr;
      s2_op_d      = s1_op_q;
      s2_addr_d    = s1_addr_q;
      // write data sampled at edge 2 or edge 3 of the command
      mem_we = pipeline_mode ? (s2_op_q == SBS_OP_WRITE) : (s1_op_q == SBS_OP_WRITE);
      mem_re = (s1_op_d == SBS_OP_READ);
      rd1_d  = (s1_op_d == SBS_OP_READ);
      rd2_d  = rd1_q;
      pipe_d = mem_rdata;
      // read path one stage shorter in flow-through, mirrors the write side
      rdata_d    = pipeline_mode ? pipe_q : mem_rdata;
      rdata_oe_d = pipeline_mode ? rd2_q : rd1_q;
    end
    if (quiet_d) begin
      rdata_oe_d = 1'b0;
    end
  end

  // upper bits always from the loaded base
  assign cur_addr = {base_d[`SBS_ADDR_W-1:2],
                     sbs_burst_lo(base_d[1:0], step_d, interleave_mode)};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      base_q       <= '0;
      step_q       <= `SBS_STEP_RESET;
      s1_op_q      <= SBS_OP_DESEL;
      s1_addr_q    <= '0;
      s2_op_q      <= SBS_OP_DESEL;
      s2_addr_q    <= '0;
      burst_addr_q <= '0;
      rd1_q        <= 1'b0;
      rd2_q        <= 1'b0;
      pipe_q       <= '0;
      rdata_q      <= '0;
      rdata_oe_q   <= 1'b0;
    end else begin
      base_q       <= base_d;
      step_q       <= step_d;
      s1_op_q      <= s1_op_d;
      s1_addr_q    <= s1_addr_d;
      s2_op_q      <= s2_op_d;
      s2_addr_q    <= s2_addr_d;
      burst_addr_q <= burst_addr_d;
      rd1_q        <= rd1_d;
      rd2_q        <= rd2_d;
      pipe_q       <= pipe_d;
      rdata_q      <= rdata_d;
      rdata_oe_q   <= rdata_oe_d;
    end
  end

  // no bypass: a read of an address still in the write pipe sees old data
  sbs_mem u_mem (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (mem_we),
    .wr_addr (mem_waddr),
    .wr_data (wdata),
    .rd_en   (mem_re),
    .rd_addr (cur_addr),
    .rd_data (mem_rdata)
  );

  // ----------------------------------------
  // register slave
  // ----------------------------------------
  logic        ctrl_sleep_d;
  logic        wait_q, wait_d;
  logic [31:0] rdat_q, rdat_d;

  always_comb begin
    ctrl_sleep_d = ctrl_sleep_q;
    wait_d       = 1'b1;
    rdat_d       = rdat_q;
    if ((avs_read || avs_write) && wait_q) begin
      wait_d = 1'b0;
      if (avs_address == `SBS_REG_CTRL) begin
        rdat_d = {31'h0, ctrl_sleep_q};
      end else if (avs_address == `SBS_REG_STATUS) begin
        rdat_d = {24'h0, s1_op_q, step_q, interleave_mode, pipeline_mode,
                  (sleep_q == SBS_ENTER || sleep_q == SBS_WAKE), asleep_q};
      end else begin
        rdat_d = 32'h0;
      end
    end
    if (avs_write && !wait_q && avs_address == `SBS_REG_CTRL && avs_byteenable[0]) begin
      ctrl_sleep_d = avs_writedata[`SBS_CTRL_SLEEP_BIT];
    end
  end

  // bus stalls too while clk_en is low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_sleep_q <= `SBS_CTRL_RESET;
      wait_q       <= 1'b1;
      rdat_q       <= 32'h0;
    end else if (clk_en) begin
      ctrl_sleep_q <= ctrl_sleep_d;
      wait_q       <= wait_d;
      rdat_q       <= rdat_d;
    end
  end

  assign rdata           = rdata_q;
  assign rdata_oe        = rdata_oe_q;
  assign asleep          = asleep_q;
  assign burst_addr      = burst_addr_q;
  assign avs_readdata    = rdat_q;
  assign avs_waitrequest = wait_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_sleep_entry_time: assert property ((sleep_q == SBS_AWAKE && sleep_req_eff) ##1
    sleep_req_eff ##1 sleep_req_eff |=> asleep_q)
    else $error("sleep not entered two cycles after request");
  a_sleep_not_early: assert property ((sleep_q == SBS_AWAKE && sleep_req_eff) |=>
    !asleep_q ##1 !asleep_q)
    else $error("sleep entered too early");
  a_wake_time: assert property ((sleep_q == SBS_ASLEEP && !sleep_req_eff) ##1
    !sleep_req_eff ##1 !sleep_req_eff |=> sleep_q == SBS_AWAKE && !asleep_q)
    else $error("wake-up not two cycles");
  a_asleep_quiet: assert property (asleep_q |-> !rdata_oe_q)
    else $error("data driven while asleep");
  a_sleep_retain: assert property (sleep_q == SBS_ASLEEP |=>
    $stable(base_q) && $stable(step_q) && $stable(s1_op_q))
    else $error("state changed while asleep");
  a_hold_freeze: assert property (!clk_en |=>
    $stable(s1_op_q) && $stable(s2_op_q) && $stable(rd2_q) && $stable(step_q))
    else $error("state moved on a held edge");
  a_load_start: assert property ((run && !advance_load && chip_sel) |=>
    step_q == 2'h0 && base_q == $past(addr_in))
    else $error("burst start not loaded");
  a_burst_step: assert property ((run && advance_load) |=>
    step_q == 2'(($past(step_q) + 2'h1)))
    else $error("burst counter did not advance");
  a_burst_order: assert property ($past(run) |-> burst_addr_q ==
    {base_q[`SBS_ADDR_W-1:2], sbs_burst_lo(base_q[1:0], step_q, interleave_mode)})
    else $error("burst address sequence wrong");
  a_write_flow: assert property ((run && !pipeline_mode && !advance_load && chip_sel
    && write_req && byte_wr) ##1 run |-> mem_we && mem_waddr == $past(cur_addr))
    else $error("flow write not at second edge");
  a_write_pipe: assert property ((run && pipeline_mode && !advance_load && chip_sel
    && write_req && byte_wr) ##1 run ##1 run |-> mem_we)
    else $error("pipeline write not at third edge");
  a_read_timing: assert property ((run && !advance_load && chip_sel && !write_req)
    ##1 run ##1 (run && pipeline_mode) |=> rdata_oe_q)
    else $error("pipeline read data late");

  c_full_burst: cover property ((run && !advance_load && chip_sel) ##1
    (run && advance_load) [*4]);
  c_read_then_write: cover property ((run && !advance_load && chip_sel && !write_req)
    ##1 (run && !advance_load && chip_sel && write_req && byte_wr));
  c_sleep_cycle: cover property (asleep_q ##[1:40] (sleep_q == SBS_AWAKE));

endmodule

// >>> tb/sbs_host.sv
`include "sbs_defines.svh"

module sbs_host (
  input  wire logic                   ref_clk,
  input  wire logic                   pipe,
  output logic                        clk_en,
  output logic [`SBS_ADDR_W-1:0]      addr_in,
  output logic                        advance_load,
  output logic                        chip_sel,
  output logic                        write_req,
  output logic                        byte_wr,
  output logic [`SBS_DATA_W-1:0]      wdata,
  output logic                        sleep_request
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [`SBS_DATA_W-1:0] d_cur;
  logic [`SBS_DATA_W-1:0] d_s1;

  initial begin
    clk_en        = 1'b1;
    addr_in       = 4'h0;
    advance_load  = 1'b0;
    chip_sel      = 1'b0;
    write_req     = 1'b0;
    byte_wr       = 1'b0;
    d_cur         = 18'h0;
    sleep_request = 1'b0;
  end

  // ----------------------------------------
  // late write data
  // ----------------------------------------
  // data trails its command by one edge (flow) or two (pipeline)
  always @(posedge ref_clk) begin
    d_s1  <= d_cur;
    wdata <= pipe ? d_s1 : d_cur;
  end

  // ----------------------------------------
  // commands, one per edge
  // ----------------------------------------
  task automatic cmd(input logic al, input logic cs, input logic wr, input logic bw,
                     input logic [3:0] a, input logic [17:0] d);
    @(posedge ref_clk);
    advance_load <= al;
    chip_sel     <= cs;
    write_req    <= wr;
    byte_wr      <= bw;
    // unused address and data keep moving so a stale value cannot pass
    addr_in      <= al ? ~addr_in : a;
    d_cur        <= (wr & bw) ? d : ~d_cur;
  endtask

  // deselect only: used to drain and during wake recovery
  task automatic idle(input int n);
    repeat (n) cmd(1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 18'h0);
  endtask

  task automatic set_en(input logic v);
    @(posedge ref_clk);
    clk_en <= v;
  endtask

  task automatic set_sleep(input logic v);
    @(posedge ref_clk);
    sleep_request <= v;
  endtask
endmodule

// >>> tb/testbench.sv
`include "sbs_defines.svh"

`define CHK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); \
  end \
end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                    ref_clk;
  logic                    rst;
  logic                    burst_order_select;
  logic                    flow_through_select;
  logic                    clk_en;
  logic [`SBS_ADDR_W-1:0]  addr_in;
  logic                    advance_load;
  logic                    chip_sel;
  logic                    write_req;
  logic                    byte_wr;
  logic [`SBS_DATA_W-1:0]  wdata;
  logic                    sleep_request;
  logic [`SBS_DATA_W-1:0]  rdata;
  logic                    rdata_oe;
  logic                    asleep;
  logic [`SBS_ADDR_W-1:0]  burst_addr;
  logic [3:0]              avs_address;
  logic                    avs_read;
  logic                    avs_write;
  logic [31:0]             avs_writedata;
  logic [3:0]              avs_byteenable;
  logic [31:0]             avs_readdata;
  logic                    avs_waitrequest;
  logic [`SBS_DATA_W-1:0]  mem [16];
  logic [31:0]             q;
  int                      err_count;
  int                      comparisons;

  sbs_ctrl dut (
    .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .addr_in(addr_in),
    .advance_load(advance_load), .chip_sel(chip_sel), .write_req(write_req),
    .byte_wr(byte_wr), .wdata(wdata), .burst_order_select(burst_order_select),
    .flow_through_select(flow_through_select), .sleep_request(sleep_request),
    .rdata(rdata), .rdata_oe(rdata_oe), .asleep(asleep), .burst_addr(burst_addr),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
  );

  sbs_host host (
    .ref_clk(ref_clk), .pipe(flow_through_select), .clk_en(clk_en), .addr_in(addr_in),
    .advance_load(advance_load), .chip_sel(chip_sel), .write_req(write_req),
    .byte_wr(byte_wr), .wdata(wdata), .sleep_request(sleep_request)
  );

  always #25 ref_clk = ~ref_clk;

  task automatic summarize();
    if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic guard(input int n);
    if (n >= 20) begin
      err_count++;
      summarize();
    end
  endtask

  // ----------------------------------------
  // bus and sequencing helpers
  // ----------------------------------------
  task automatic avs(input logic wr, input logic [3:0] ad, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    @(posedge ref_clk);
    avs_address    <= ad;
    avs_read       <= ~wr;
    avs_write      <= wr;
    avs_writedata  <= d;
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    guard(n);
  endtask

  task automatic wait_sleep(input logic v, output int n);
    n = 0;
    while (asleep !== v && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    guard(n);
  endtask

  // straps change only while reset holds the device
  task automatic do_reset(input logic ilv, input logic pipe);
    @(posedge ref_clk);
    rst                 <= 1'b1;
    burst_order_select  <= ilv;
    flow_through_select <= pipe;
    repeat (16) @(posedge ref_clk);
    #1;
    `CHK(asleep, 1'b0)
    @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // load plus continues; cycles from index ab on are write aborts
  task automatic burst(input logic wr, input logic [3:0] b, input int n, input int ab,
                       input int tail);
    logic [3:0]  ea [16];
    logic [17:0] d;
    int          lat;
    lat = flow_through_select ? 2 : 1;
    for (int i = 0; i < n + tail; i++) begin
      if (i < n) begin
        ea[i] = {b[3:2], burst_order_select ? b[1:0] ^ i[1:0] : b[1:0] + i[1:0]};
        d = {b, 10'h2B3, ea[i]};
        host.cmd(i > 0, 1'b1, wr, i < ab, ea[i], d);
        if (wr && i < ab) mem[ea[i]] = d;
      end else begin
        host.cmd(1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 18'h0);
      end
      #1;
      if (i > 0 && i <= n) `CHK(burst_addr, ea[i-1])
      if (!wr && i > lat && i - lat <= n)
        `CHK({rdata_oe, rdata}, {1'b1, mem[ea[i-1-lat]]})
    end
  endtask

  task automatic t_hold();
    logic [3:0]  a;
    logic [18:0] o;
    host.cmd(1'b0, 1'b1, 1'b0, 1'b1, 4'h6, 18'h0);
    host.cmd(1'b1, 1'b0, 1'b0, 1'b1, 4'h0, 18'h0);
    host.set_en(1'b0);
    #1;
    a = burst_addr;
    o = {rdata_oe, rdata};
    repeat (3) begin
      @(posedge ref_clk);
      #1;
      `CHK({burst_addr, rdata_oe, rdata}, {a, o})
    end
    host.set_en(1'b1);
    host.idle(3);
  endtask

  task automatic t_regs();
    int n;
    avs(1'b0, 4'h4, 32'h0, 4'hF);
    `CHK(q[3:0], 4'h4)
    avs(1'b0, 4'h8, 32'h0, 4'hF);
    `CHK(q, 32'h0)
    avs(1'b1, 4'h0, 32'h1, 4'h0);
    avs(1'b0, 4'h0, 32'h0, 4'hF);
    `CHK(q[0], 1'b0)
    avs(1'b1, 4'h0, 32'h1, 4'hF);
    wait_sleep(1'b1, n);
    avs(1'b0, 4'h4, 32'h0, 4'hF);
    `CHK(q[0], 1'b1)
    avs(1'b1, 4'h0, 32'h0, 4'hF);
    wait_sleep(1'b0, n);
    host.idle(2);
  endtask

  task automatic t_sleep();
    int         n;
    logic [3:0] a;
    host.idle(3);
    #1;
    a = burst_addr;
    host.set_en(1'b0);
    host.set_sleep(1'b1);
    wait_sleep(1'b1, n);
    `CHK(n > 1 && n < 7, 1'b1)
    host.set_en(1'b1);
    host.cmd(1'b0, 1'b1, 1'b0, 1'b1, ~a, 18'h0);
    host.idle(3);
    #1;
    `CHK({burst_addr, rdata_oe}, {a, 1'b0})
    host.set_sleep(1'b0);
    wait_sleep(1'b0, n);
    host.idle(2);
    #1;
    `CHK(burst_addr, a)
    burst(1'b0, 4'h6, 1, 9, 3);
  endtask

  initial begin
    ref_clk             = 1'b0;
    rst                 = 1'b1;
    burst_order_select  = 1'b0;
    flow_through_select = 1'b1;
    avs_address         = 4'h0;
    avs_read            = 1'b0;
    avs_write           = 1'b0;
    avs_writedata       = 32'h0;
    avs_byteenable      = 4'h0;
    err_count           = 0;
    comparisons         = 0;
    do_reset(1'b0, 1'b1);
    // write straight into read, no idle in between
    burst(1'b1, 4'h6, 6, 4, 0);
    burst(1'b0, 4'h6, 4, 9, 3);
    t_hold();
    t_regs();
    t_sleep();
    do_reset(1'b1, 1'b0);
    avs(1'b0, 4'h4, 32'h0, 4'hF);
    `CHK(q[3:2], 2'h2)
    burst(1'b1, 4'hB, 6, 4, 0);
    // aborts from the load edge on must leave the array alone
    burst(1'b1, 4'hB, 4, 0, 0);
    burst(1'b0, 4'hB, 4, 9, 2);
    summarize();
  end
endmodule
